// file: dv/rtc_alarm_match_irq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_match_irq_asserts #(parameter int PULSE_LEN = 4) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_time_tick,
   input wire rtc_alarm_pkg::reg_req_t i_req,
   input wire logic i_bat_above_main,
   input wire logic i_main_below_trip,
   input wire logic [7:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic o_on_battery,
   input wire logic o_serial_enabled,
   input wire logic o_alert_out,
   input wire logic o_alert_oe
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   AST_PIN_LOW: assert property (!o_alert_out) else $error("pin high");
   AST_ALERT_TICK: assert property ($rose(o_alert_oe) |-> $past(i_time_tick)) else $error("no tick");
   AST_READ_CAUSE: assert property (o_rvalid |-> $past(i_req.rd)) else $error("no read");
   AST_READ_LOCKED: assert property (
      (i_req.rd && !o_serial_enabled && !$past(o_serial_enabled)) ##1 !o_serial_enabled |-> !o_rvalid)
      else $error("read answered");
   AST_MAINS_SERIAL: assert property (!o_on_battery [*3] |-> o_serial_enabled) else $error("serial off");
   AST_MAINS_STAY: assert property (
      (!i_bat_above_main && !i_main_below_trip) [*8] |-> !o_on_battery) else $error("battery");
   AST_BOTH_SWITCH: assert property (
      (i_bat_above_main && i_main_below_trip) [*8] |-> o_on_battery) else $error("mains");
   AST_RDATA_HOLD: assert property (!o_rvalid |-> $stable(o_rdata)) else $error("rdata moved");
endmodule
bind rtc_alarm_match_irq rtc_alarm_match_irq_asserts #(.PULSE_LEN(PULSE_LEN)) rtc_alarm_match_irq_asserts_i (
   .i_clk, .i_rst, .i_time_tick, .i_req, .i_bat_above_main, .i_main_below_trip,
   .o_rdata, .o_rvalid, .o_on_battery, .o_serial_enabled, .o_alert_out, .o_alert_oe);
`default_nettype wire

// file: dv/rtc_alarm_match_irq_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_match_irq_bench;
   localparam int PL = 4;
   localparam logic [2:0] st_a = rtc_alarm_pkg::ADDR_STATUS;
   localparam logic [2:0] irq_a = rtc_alarm_pkg::ADDR_IRQ_SETUP;
   logic i_clk = 0, i_rst = 1, bat = 0, low = 0, tick = 0, rvalid, on_bat, ser_en, a_out, a_oe;
   logic [7:0] rdata;
   logic [7:0] exp_q[$];
   rtc_alarm_pkg::rtc_time_t tm = '0;
   rtc_alarm_pkg::reg_req_t req;
   int mismatches = 0, compares = 0, cyc = 0, seed = 32'h84FF;
   wire logic pin = a_oe ? a_out : 1'b1;
   initial forever #4 i_clk = ~i_clk;
   rtc_host_model rtc_host_model_i (.i_clk(i_clk), .o_req(req));
   rtc_alarm_match_irq #(.PULSE_LEN(PL)) rtc_alarm_match_irq_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
      .i_time(tm), .i_time_tick(tick), .i_req(req), .i_bat_above_main(bat), .i_main_below_trip(low),
      .o_rdata(rdata), .o_rvalid(rvalid), .o_on_battery(on_bat), .o_serial_enabled(ser_en),
      .o_alert_out(a_out), .o_alert_oe(a_oe));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      compares++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected at %0t seen %0h expected %0h", $time, seen, want);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      rtc_host_model_i.xfer(1'b0, a, 8'h00);
   endtask
   task automatic load(input logic [47:0] v);
      for (int a = 0; a < 6; a++)
         rtc_host_model_i.xfer(1'b1, 3'(a), v[47-8*a -: 8]);
   endtask
   task automatic step(input logic [7:0] s, input logic [7:0] m, input logic want);
      @(posedge i_clk) #1;
      tm = '{s, m, 8'h11, 8'h01, 8'h01, 8'h03};
      tick = 1;
      @(posedge i_clk) #1;
      tick = 0;
      check(8'(pin), 8'(want));
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   always @(negedge i_clk) begin
      if (rvalid === 1'b1)
         check(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
      if (++cyc > 3000) begin
         mismatches++;
         report_and_stop();
      end
   end
   initial begin
      wt(10);
      i_rst = 0;
      for (int a = 0; a < 8; a++)
         rd(3'(a), 8'h00);
      load(48'h00B091818100);
      step(8'h00, 8'h30, 1);
      step(8'h59, 8'h29, 1);
      rtc_host_model_i.xfer(1'b1, irq_a, 8'h20);
      for (int a = 0; a < 3; a++)
         step(8'($random(seed)), 8'h29, 1);
      step(8'h00, 8'h30, 0);
      wt(8);
      check(8'(pin), 8'h00);
      rd(st_a, 8'h01);
      rtc_host_model_i.xfer(1'b1, st_a, 8'h00);
      wt(2);
      check(8'(pin), 8'h01);
      load(48'hB00000000000);
      rtc_host_model_i.xfer(1'b1, irq_a, 8'hA0);
      step(8'h30, 8'h31, 0);
      wt(PL - 2);
      check(8'(pin), 8'h00);
      wt(4);
      check(8'(pin), 8'h01);
      step(8'h31, 8'h31, 1);
      step(8'h30, 8'h32, 0);
      rd(st_a, 8'h01);
      rtc_host_model_i.xfer(1'b1, st_a, 8'h00);
      bat = 1;
      wt(8);
      check({6'h0, on_bat, ser_en}, 8'h02);
      rtc_host_model_i.xfer(1'b1, irq_a, 8'h00);
      rtc_host_model_i.xfer(1'b0, st_a, 8'h00);
      bat = 0;
      wt(8);
      rd(irq_a, 8'hA0);
      rtc_host_model_i.xfer(1'b1, st_a, 8'h04);
      bat = 1;
      wt(8);
      check({6'h0, on_bat, ser_en}, 8'h01);
      low = 1;
      wt(8);
      check({6'h0, on_bat, ser_en}, 8'h03);
      step(8'h31, 8'h32, 1);
      step(8'h30, 8'h33, 0);
      rd(st_a, 8'h0D);
      rtc_host_model_i.xfer(1'b1, st_a, 8'h06);
      wt(2);
      check({6'h0, on_bat, ser_en}, 8'h02);
      rtc_host_model_i.xfer(1'b0, st_a, 8'h00);
      wt(PL + 2);
      check(8'(exp_q.size()), 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire

// file: dv/rtc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
   input wire logic i_clk,
   output var rtc_alarm_pkg::reg_req_t o_req
);
   initial o_req = '0;
   // one-cycle strobe; released fields show inverted values
   task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk) #1;
      o_req = '{w, !w, a, d};
      @(posedge i_clk) #1;
      o_req = '{1'b0, 1'b0, ~a, ~d};
   endtask
endmodule
`default_nettype wire

// file: rtl/rtc_alarm_compare.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_compare (
   input wire logic [47:0] i_match,
   input wire rtc_alarm_pkg::rtc_time_t i_time,
   output logic o_hit
);
   logic [47:0] now;
   logic [5:0] field_ok;

   assign now = {i_time.second, i_time.minute, i_time.hour, i_time.date, i_time.month, i_time.weekday};

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_field
         // disabled field never blocks
         assign field_ok[g] = !i_match[g*8+7] || (i_match[g*8+6 -: 7] == now[g*8+6 -: 7]);
      end
   endgenerate

   // all fields disabled is no alarm
   assign o_hit = (&field_ok) && (|{i_match[47], i_match[39], i_match[31], i_match[23], i_match[15], i_match[7]});
endmodule
`default_nettype wire

// file: rtl/rtc_alarm_match_irq.sv
// Summary of operation
// - alarm registers hold a BCD value in the low bits, bit 7 enables comparison
// - a field whose enable bit is clear never blocks the match
// - pulse-select zero gives single-event alarm mode
// - pulse-select (bit 7) with arm gives a pulsed alarm on every match
// - match is evaluated as time advances into the programmed value
// - a match sets the alarm flag and pulls the alert pin low
// - in pulsed mode the flag sets every trigger, pulses need no clearing
// - seconds-only at 30 with pulsed mode interrupts once a minute
// - legacy backup keeps alarms, and keeps serial access unless the bus lock is set
// - standard backup disables everything but timekeeping, serial access too
// - legacy mode runs from battery when it exceeds main and main is below trip
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_match_irq #(
   parameter int PULSE_LEN = rtc_alarm_pkg::PULSE_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire rtc_alarm_pkg::rtc_time_t i_time,
   input wire logic i_time_tick,
   input wire rtc_alarm_pkg::reg_req_t i_req,
   input wire logic i_bat_above_main,
   input wire logic i_main_below_trip,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   output logic o_on_battery,
   output logic o_serial_enabled,
   output logic o_alert_out,
   output logic o_alert_oe
);
   logic [7:0] match_r [0:5];
   logic [7:0] irq_setup_r;
   logic [7:0] power_cfg_r;
   logic flag_r;
   logic [2:0] bat_sync_r;
   logic [2:0] trip_sync_r;
   logic bat_cmp_r;
   logic trip_cmp_r;
   logic on_bat_r;
   logic hit;
   logic hit_d_r;
   logic fire;
   logic alarm_live;
   logic bus_ok;
   logic req_ok;
   logic [31:0] pulse_cnt_r;
   logic pulse_low_r;
   logic arm;
   logic pulse_sel;
   logic legacy;
   logic [47:0] match_flat;
   logic match_wr;

   assign arm = irq_setup_r[rtc_alarm_pkg::BIT_ALARM_ARM];
   assign pulse_sel = irq_setup_r[rtc_alarm_pkg::BIT_PULSE_SEL];
   assign legacy = power_cfg_r[rtc_alarm_pkg::BIT_LEGACY];
   assign match_flat = {match_r[0], match_r[1], match_r[2], match_r[3], match_r[4], match_r[5]};

   rtc_alarm_compare u_cmp (
      .i_match(match_flat),
      .i_time(i_time),
      .o_hit(hit)
   );

   // pin-level supply comparators, three stages, change taken when last two agree
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         bat_sync_r <= 3'h0;
         trip_sync_r <= 3'h0;
         bat_cmp_r <= 1'b0;
         trip_cmp_r <= 1'b0;
      end else if (i_ce) begin
         bat_sync_r <= {bat_sync_r[1:0], i_bat_above_main};
         trip_sync_r <= {trip_sync_r[1:0], i_main_below_trip};
         if (bat_sync_r[2] == bat_sync_r[1]) begin
            bat_cmp_r <= bat_sync_r[2];
         end
         if (trip_sync_r[2] == trip_sync_r[1]) begin
            trip_cmp_r <= trip_sync_r[2];
         end
      end
   end

   // switchover decision
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         on_bat_r <= 1'b0;
      end else if (i_ce) begin
         if (legacy) begin
            on_bat_r <= bat_cmp_r && trip_cmp_r;
         end else begin
            on_bat_r <= bat_cmp_r || trip_cmp_r;
         end
      end
   end

   // serial access allowed on main power, or legacy backup without bus lock
   assign bus_ok = !on_bat_r ||
      (legacy && !power_cfg_r[rtc_alarm_pkg::BIT_BUS_LOCK]);
   assign req_ok = i_ce && bus_ok;
   // alarms live on main power, or in legacy backup
   assign alarm_live = !on_bat_r || legacy;

   // a write to any match register
   assign match_wr = req_ok && i_req.wr && (i_req.addr < rtc_alarm_pkg::ADDR_IRQ_SETUP);

   // rising edge of the match, sampled when the time advances
   // reprogramming forgets the old match so the new time can fire at once
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         hit_d_r <= 1'b0;
      end else if (match_wr) begin
         hit_d_r <= 1'b0;
      end else if (i_ce && i_time_tick) begin
         hit_d_r <= hit;
      end
   end
   assign fire = i_ce && i_time_tick && hit && !hit_d_r && arm && alarm_live;

   // per-field match registers, one writer per entry
   genvar f;
   generate
      for (f = 0; f < rtc_alarm_pkg::NUM_FIELDS; f++) begin : g_match
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               match_r[f] <= rtc_alarm_pkg::RST_MATCH;
            end else if (match_wr && (i_req.addr == 3'(f))) begin
               match_r[f] <= i_req.wdata;
            end
         end
      end
   endgenerate

   // control register writes
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_setup_r <= rtc_alarm_pkg::RST_IRQ_SETUP;
         power_cfg_r <= rtc_alarm_pkg::RST_POWER_CFG;
      end else if (req_ok && i_req.wr) begin
         case (i_req.addr)
            rtc_alarm_pkg::ADDR_IRQ_SETUP: begin
               irq_setup_r <= i_req.wdata;
            end
            rtc_alarm_pkg::ADDR_STATUS: begin
               // flag bit is not stored here, only bus lock and legacy select
               power_cfg_r <= {5'h00, i_req.wdata[2:1], 1'b0};
            end
            default: begin
            end
         endcase
      end
   end

   // alarm flag: set wins over a clearing write
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_r <= 1'b0;
      end else if (i_ce) begin
         if (fire) begin
            flag_r <= 1'b1;
         end else if (req_ok && i_req.wr && i_req.addr == rtc_alarm_pkg::ADDR_STATUS &&
               !i_req.wdata[rtc_alarm_pkg::BIT_FLAG]) begin
            flag_r <= 1'b0;
         end
      end
   end

   // pulsed-mode low timer
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pulse_cnt_r <= 32'h0000_0000;
         pulse_low_r <= 1'b0;
      end else if (i_ce) begin
         if (fire && pulse_sel) begin
            pulse_cnt_r <= 32'(PULSE_LEN - 1);
            pulse_low_r <= 1'b1;
         end else if (pulse_cnt_r != 32'h0000_0000) begin
            pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
            // drop on the last count so the pin is low for exactly the pulse length
            if (pulse_cnt_r == 32'h0000_0001) begin
               pulse_low_r <= 1'b0;
            end
         end else begin
            pulse_low_r <= 1'b0;
         end
      end
   end

   // open-drain alert pin, low while enabled
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_alert_oe <= 1'b0;
         o_alert_out <= 1'b0;
      end else if (i_ce) begin
         o_alert_out <= 1'b0;
         if (pulse_sel) begin
            o_alert_oe <= pulse_low_r || (fire && pulse_sel);
         end else begin
            o_alert_oe <= flag_r || fire;
         end
      end
   end

   // read port
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
      end else if (i_ce) begin
         o_rvalid <= req_ok && i_req.rd;
         if (req_ok && i_req.rd) begin
            if (i_req.addr == rtc_alarm_pkg::ADDR_IRQ_SETUP) begin
               o_rdata <= irq_setup_r;
            end else if (i_req.addr == rtc_alarm_pkg::ADDR_STATUS) begin
               o_rdata <= {4'h0, on_bat_r, power_cfg_r[2:1], flag_r};
            end else begin
               o_rdata <= match_r[i_req.addr];
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_on_battery <= 1'b0;
         o_serial_enabled <= 1'b0;
      end else if (i_ce) begin
         o_on_battery <= on_bat_r;
         o_serial_enabled <= bus_ok;
      end
   end
endmodule
`default_nettype wire

// file: rtl/rtc_alarm_pkg.sv
package rtc_alarm_pkg;

   // register indices inside the alarm/control window of the serial register port
   localparam logic [2:0] ADDR_SECOND = 3'h0;
   localparam logic [2:0] ADDR_MINUTE = 3'h1;
   localparam logic [2:0] ADDR_HOUR = 3'h2;
   localparam logic [2:0] ADDR_DATE = 3'h3;
   localparam logic [2:0] ADDR_MONTH = 3'h4;
   localparam logic [2:0] ADDR_WEEKDAY = 3'h5;
   localparam logic [2:0] ADDR_IRQ_SETUP = 3'h6;
   localparam logic [2:0] ADDR_STATUS = 3'h7;

   localparam int NUM_FIELDS = 6;
   localparam int BIT_FIELD_EN = 7;
   localparam int BIT_ALARM_ARM = 5;
   localparam int BIT_PULSE_SEL = 7;
   localparam int BIT_FLAG = 0;
   localparam int BIT_BUS_LOCK = 1;
   localparam int BIT_LEGACY = 2;

   localparam logic [7:0] RST_MATCH = 8'h00;
   localparam logic [7:0] RST_IRQ_SETUP = 8'h00;
   localparam logic [7:0] RST_POWER_CFG = 8'h00;

   // pulsed-mode low time on the alert pin
   localparam int PULSE_NS = 250_000_000;
   localparam int CLK_NS = 8;
   localparam int PULSE_CYCLES = (PULSE_NS + CLK_NS - 1) / CLK_NS;

   typedef struct packed {
      logic [7:0] second;
      logic [7:0] minute;
      logic [7:0] hour;
      logic [7:0] date;
      logic [7:0] month;
      logic [7:0] weekday;
   } rtc_time_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

endpackage
